/* File: dpa_pkg.sv */
package dpa_pkg;
    // ----------------------------------------
    // Host command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_READ = 8'h08;
    localparam logic [7:0] CMD_WRITE = 8'h18;
    localparam logic [7:0] CMD_STATUS = 8'h38;
    localparam logic [7:0] CMD_REG_WRITE = 8'h48;
    localparam logic [7:0] CMD_REG_READ = 8'h58;
    localparam logic [7:0] CMD_QUERY = 8'h28;
    localparam logic [7:0] CMD_ANSWER_OK = 8'hF8;
    localparam logic [7:0] CMD_ANSWER_ERR = 8'hE8;
    // ----------------------------------------
    // Response status codes
    // ----------------------------------------
    localparam logic [7:0] ST_NORMAL = 8'h00;
    localparam logic [7:0] ST_BUSY = 8'h01;
    localparam logic [7:0] ST_HOST_BUSY = 8'h02;
    localparam logic [7:0] ST_RELAY_ERR = 8'h03;
    localparam logic [7:0] ST_UNIMPL = 8'h04;
    localparam logic [7:0] ST_SELFDIAG = 8'h05;
    localparam logic [7:0] ST_RELAY_RD = 8'h06;
    localparam logic [7:0] ST_RELAY_WR = 8'h07;
    // ----------------------------------------
    // Timing and address width
    // ----------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int ANSWER_WAIT_US = 1000;
    localparam int ANSWER_WAIT_CYC = ANSWER_WAIT_US * CLK_MHZ;
    localparam int SLAVE_ADDR_W = 7;
    // ----------------------------------------
    // Enumerations
    // ----------------------------------------
    typedef enum logic [2:0] {
        K_READ, K_WRITE, K_STATUS, K_REG_WRITE, K_REG_READ, K_QUERY, K_ANSWER, K_UNIMPL
    } dpa_kind_e;
    typedef enum logic [2:0] {
        S_IDLE, S_RF_BUSY, S_SER_BUSY, S_RELAY_RX, S_RELAY_QUERY, S_RELAY_ANSWER
    } dpa_state_e;
endpackage

/* File: dpa_arbiter.sv */
`timescale 1ns/10ps
// What this block does
// R01 - During a transaction, hold exclusivity; competing commands are not run normally.
// R02 - Exclusivity starts at command start, ends when its response is sent.
// R03 - Relay exclusivity spans relay command start to final relay answer.
// R04 - Host commands with a foreign slave address get no answer.
// R05 - Unknown host command codes get the unimplemented-command status.
// R06 - During RF activity: data/status busy, register ops run, relay commands error.
// R07 - A known host command during a pending host command gets serial-busy status.
// R08 - Later host commands in a busy host transaction raise no interrupt.
// R09 - Awaiting query: read, write, answer unimplemented; query advances relay.
// R10 - In relay waits, status returns relay read or write detect.
// R11 - Awaiting query: register ops give detect or self-diag; RF stop gives normal.
// R12 - Awaiting answer: read, write, query unimplemented; register ops run; answer finishes.
// R13 - JIS reader commands during exclusivity get no response.
// R14 - ISO reader commands during exclusivity with wait extension off get no response.
// R15 - Wait extension on, serial busy: select/read/write/verify get WTX, others run.
// R16 - Host command during relay reception is answered before the detect interrupt.
// R17 - After the detect interrupt, host commands follow the awaiting-query behaviour.
// R18 - Carrier loss after relay reception returns to idle.
// R19 - Each non-answer host response while awaiting answer restarts the timer.
// R20 - Answer command while awaiting answer returns to idle.
// R21 - Host fetches relay details with the single-byte query code.
// R22 - Host ends a relay with a single-byte answer code, ok or error.
// R23 - Answer-wait timer expiry returns to idle.
module dpa_arbiter #(
    parameter int ANSWER_WAIT_CYCLES = dpa_pkg::ANSWER_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [dpa_pkg::SLAVE_ADDR_W-1:0] own_addr,
    input wire logic host_cmd_start,
    input wire logic host_cmd_valid,
    input wire logic [dpa_pkg::SLAVE_ADDR_W-1:0] host_addr,
    input wire logic [7:0] host_cmd_code,
    input wire logic host_rf_stop,
    input wire logic host_selfdiag_err,
    input wire logic host_exec_done,
    input wire logic rf_cmd_start,
    input wire logic rf_iso,
    input wire logic rf_wtx_kind,
    input wire logic rf_relay,
    input wire logic rf_relay_write,
    input wire logic rf_cmd_end,
    input wire logic rf_rsp_done,
    input wire logic carrier_on,
    input wire logic wait_extension_enable,
    output logic exclusive,
    output logic host_rsp_valid,
    output logic [7:0] host_rsp_status,
    output logic host_exec,
    output logic host_irq,
    output logic relay_irq,
    output logic relay_is_write,
    output logic relay_done,
    output logic relay_fail,
    output logic relay_timeout,
    output logic rf_exec,
    output logic rf_wtx,
    output logic rf_drop
);
    import dpa_pkg::*;

    localparam int TW = $clog2(ANSWER_WAIT_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(ANSWER_WAIT_CYCLES - 1);
    localparam logic [TW-1:0] TIMER_ONE = TW'(1);

    typedef struct packed {
        dpa_state_e st;
        logic code_seen;
        logic rx_done;
        logic relay_wr;
        logic [TW-1:0] timer;
        logic rsp_valid;
        logic [7:0] rsp_status;
        logic exec;
        logic hirq;
        logic rirq;
        logic rdone;
        logic rfail;
        logic rtout;
        logic rexec;
        logic rwtx;
        logic rdrop;
    } dpa_regs_s;

    dpa_regs_s q;
    dpa_regs_s d;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Shared by the host path and the assertions
    function automatic dpa_kind_e dpa_kind(input logic [7:0] code);
        case (code)
            CMD_READ: dpa_kind = K_READ;
            CMD_WRITE: dpa_kind = K_WRITE;
            CMD_STATUS: dpa_kind = K_STATUS;
            CMD_REG_WRITE: dpa_kind = K_REG_WRITE;
            CMD_REG_READ: dpa_kind = K_REG_READ;
            CMD_QUERY: dpa_kind = K_QUERY; // R21
            CMD_ANSWER_OK, CMD_ANSWER_ERR: dpa_kind = K_ANSWER; // R22
            default: dpa_kind = K_UNIMPL; // R05
        endcase
    endfunction

    dpa_kind_e kind;
    logic hit;
    logic start_hit;
    logic host_claim;
    logic [7:0] detect;
    logic [7:0] reg_st;
    dpa_state_e rf_view;

    // Address filter; foreign transfers never reach the state machine
    assign hit = host_cmd_valid && (host_addr == own_addr); // R04
    assign start_hit = host_cmd_start && (host_addr == own_addr); // R04
    assign kind = dpa_kind(host_cmd_code);
    assign detect = q.relay_wr ? ST_RELAY_WR : ST_RELAY_RD; // R10
    assign reg_st = host_selfdiag_err ? ST_SELFDIAG : ST_NORMAL;
    // Host wins a same-cycle tie in idle, so the RF side sees it as serial busy
    assign host_claim = start_hit || (hit && kind != K_UNIMPL);
    assign rf_view = (q.st == S_IDLE && host_claim) ? S_SER_BUSY : q.st;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        d.exec = 1'b0;
        d.hirq = 1'b0;
        d.rirq = 1'b0;
        d.rdone = 1'b0;
        d.rtout = 1'b0;
        d.rexec = 1'b0;
        d.rwtx = 1'b0;
        d.rdrop = 1'b0;
        // Host transfer start opens the exclusive period before the code is known
        if (start_hit && q.st == S_IDLE) begin
            d.st = S_SER_BUSY; // R02
            d.code_seen = 1'b0;
        end
        // Host command handling
        if (hit) begin
            d.rsp_valid = 1'b1;
            if (kind == K_UNIMPL) begin
                d.rsp_status = ST_UNIMPL; // R05
                if (q.st == S_IDLE || (q.st == S_SER_BUSY && !q.code_seen)) begin
                    d.st = S_IDLE;
                end
            end else begin
                case (q.st)
                    S_IDLE, S_SER_BUSY: begin
                        if (q.st == S_IDLE || !q.code_seen) begin
                            d.rsp_valid = 1'b0; // Executor answers this one itself
                            d.exec = 1'b1; // R01
                            d.st = S_SER_BUSY; // R02
                            d.code_seen = 1'b1;
                        end else begin
                            d.rsp_status = ST_HOST_BUSY; // R07
                        end
                    end
                    S_RF_BUSY, S_RELAY_RX: begin
                        case (kind)
                            K_READ, K_WRITE, K_STATUS: d.rsp_status = ST_BUSY; // R06
                            K_REG_WRITE, K_REG_READ: d.rsp_status = reg_st; // R06
                            default: d.rsp_status = ST_RELAY_ERR; // R06
                        endcase
                    end
                    S_RELAY_QUERY: begin
                        case (kind)
                            K_STATUS: d.rsp_status = detect; // R10
                            K_REG_WRITE, K_REG_READ: begin
                                if (host_selfdiag_err) begin
                                    d.rsp_status = ST_SELFDIAG; // R11
                                end else if (kind == K_REG_WRITE && host_rf_stop) begin
                                    d.rsp_status = ST_NORMAL; // R11
                                end else begin
                                    d.rsp_status = detect; // R11
                                end
                            end
                            K_QUERY: begin
                                d.rsp_status = ST_NORMAL; // R09
                                d.st = S_RELAY_ANSWER;
                                d.timer = '0;
                            end
                            default: d.rsp_status = ST_UNIMPL; // R09
                        endcase
                    end
                    S_RELAY_ANSWER: begin
                        case (kind)
                            K_STATUS: d.rsp_status = detect; // R10
                            K_REG_WRITE, K_REG_READ: d.rsp_status = reg_st; // R12
                            K_ANSWER: begin
                                d.rsp_status = ST_NORMAL; // R12
                                d.st = S_IDLE; // R20
                                d.rdone = 1'b1;
                                d.rfail = (host_cmd_code == CMD_ANSWER_ERR); // R22
                            end
                            default: d.rsp_status = ST_UNIMPL; // R12
                        endcase
                    end
                    default: d.rsp_status = ST_BUSY;
                endcase
            end
        end
        // State-driven progress
        case (q.st)
            S_SER_BUSY: begin
                // Only the executing command raises the interrupt
                if (host_exec_done && q.code_seen) begin
                    d.st = S_IDLE; // R02
                    d.hirq = 1'b1; // R08
                end
            end
            S_RF_BUSY: begin
                if (rf_rsp_done) begin
                    d.st = S_IDLE; // R02
                end
            end
            S_RELAY_RX: begin
                if (rf_cmd_end) begin
                    d.rx_done = 1'b1;
                end
                // A host answer this cycle pushes the interrupt one cycle back
                if (q.rx_done && !hit) begin
                    d.rirq = 1'b1; // R16
                    d.st = S_RELAY_QUERY; // R17
                end
            end
            S_RELAY_ANSWER: begin
                if (hit && kind != K_ANSWER) begin
                    d.timer = '0; // R19
                end else if (!hit) begin
                    if (q.timer >= TIMER_LAST) begin
                        d.st = S_IDLE; // R23
                        d.rtout = 1'b1; // R23
                    end else begin
                        d.timer = q.timer + TIMER_ONE;
                    end
                end
            end
            default: ;
        endcase
        // Reader/writer command arbitration
        if (rf_cmd_start) begin
            case (rf_view)
                S_IDLE: begin
                    if (rf_relay) begin
                        d.st = S_RELAY_RX; // R03
                        d.rx_done = 1'b0;
                        d.relay_wr = rf_relay_write;
                    end else begin
                        d.st = S_RF_BUSY; // R02
                        d.rexec = 1'b1;
                    end
                end
                S_SER_BUSY: begin
                    if (rf_iso && wait_extension_enable) begin
                        d.rwtx = rf_wtx_kind; // R15
                        d.rexec = !rf_wtx_kind; // R15
                    end else begin
                        d.rdrop = 1'b1; // R13 R14
                    end
                end
                default: d.rdrop = 1'b1; // R13 R14 R15
            endcase
        end
        // Carrier loss abandons any RF or relay activity
        if (!carrier_on && (q.st == S_RF_BUSY || q.st == S_RELAY_RX
                || q.st == S_RELAY_QUERY || q.st == S_RELAY_ANSWER)) begin
            d.st = S_IDLE; // R18
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign exclusive = (q.st != S_IDLE); // R01 R02 R03
    assign host_rsp_valid = q.rsp_valid;
    assign host_rsp_status = q.rsp_status;
    assign host_exec = q.exec;
    assign host_irq = q.hirq;
    assign relay_irq = q.rirq;
    assign relay_is_write = q.relay_wr;
    assign relay_done = q.rdone;
    assign relay_fail = q.rfail;
    assign relay_timeout = q.rtout;
    assign rf_exec = q.rexec;
    assign rf_wtx = q.rwtx;
    assign rf_drop = q.rdrop;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rx_with_host;
        q.st == S_RELAY_RX && q.rx_done && hit && clk_en && carrier_on;
    endsequence
    sequence s_host_then_irq;
        host_rsp_valid && !relay_irq;
    endsequence

    a_addr_silent: assert property (clk_en && host_cmd_valid && host_addr != own_addr // R04
        |=> !host_rsp_valid) else $error("foreign address answered");
    a_unimpl_code: assert property (clk_en && hit && kind == K_UNIMPL // R05
        |=> host_rsp_valid && host_rsp_status == ST_UNIMPL) else $error("unknown code");
    a_rf_busy_data: assert property (clk_en && hit && q.st == S_RF_BUSY // R06
        && kind == K_READ |=> host_rsp_status == ST_BUSY) else $error("no busy in RF");
    a_host_busy: assert property (clk_en && hit && q.st == S_SER_BUSY && q.code_seen // R07
        && kind != K_UNIMPL |=> host_rsp_status == ST_HOST_BUSY && !host_exec)
        else $error("no host busy");
    a_jis_silent: assert property (clk_en && rf_cmd_start && !rf_iso && rf_view != S_IDLE // R13
        |=> rf_drop && !rf_exec && !rf_wtx) else $error("JIS answered");
    a_wtx_reply: assert property (clk_en && rf_cmd_start && rf_iso && rf_wtx_kind // R15
        && wait_extension_enable && rf_view == S_SER_BUSY |=> rf_wtx) else $error("no WTX");
    // The irq may slip again if the next cycle brings another host hit or a freeze
    a_host_first: assert property (s_rx_with_host |=> s_host_then_irq // R16
        and (clk_en && !hit && carrier_on |=> relay_irq)) else $error("irq before host answer");
    a_carrier_idle: assert property (clk_en && !carrier_on && q.st == S_RELAY_QUERY // R18
        |=> !exclusive) else $error("carrier loss ignored");
    a_timer_restart: assert property (clk_en && hit && q.st == S_RELAY_ANSWER && carrier_on // R19
        && kind != K_ANSWER |=> q.timer == '0 && q.st == S_RELAY_ANSWER)
        else $error("timer not restarted");
    a_answer_idle: assert property (clk_en && hit && q.st == S_RELAY_ANSWER // R20
        && kind == K_ANSWER |=> q.st == S_IDLE && relay_done) else $error("answer ignored");
    a_timeout_end: assert property (clk_en && q.st == S_RELAY_ANSWER && !hit && carrier_on // R23
        && q.timer >= TIMER_LAST |=> relay_timeout && !exclusive) else $error("no timeout");
endmodule // dpa_arbiter

/* File: dpa_far_end.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Far side: host executor and RF responder
// ----------------------------------------
module dpa_far_end (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_exec,
    input wire logic rf_exec,
    input wire logic [7:0] lat,
    output logic host_exec_done,
    output logic rf_rsp_done
);
    int hc_q;
    int rc_q;
    // Each job finishes lat cycles after launch; a long lat keeps the busy window open
    always @(posedge clk) begin
        if (!rst_n) begin
            hc_q <= 0;
            rc_q <= 0;
        end else begin
            hc_q <= host_exec ? int'(lat) : ((hc_q > 0) ? hc_q - 1 : 0);
            rc_q <= rf_exec ? int'(lat) : ((rc_q > 0) ? rc_q - 1 : 0);
        end
    end
    // One-cycle completion pulses
    assign host_exec_done = (hc_q == 1);
    assign rf_rsp_done = (rc_q == 1);
endmodule // dpa_far_end

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import dpa_pkg::*;
    localparam int AW = 20;
    logic clk = 0, rst_n = 0, host_cmd_start = 0, host_cmd_valid = 0, host_rf_stop = 0;
    logic host_selfdiag_err = 0, rf_cmd_start = 0, rf_iso = 0, rf_wtx_kind = 0, rf_relay = 0;
    logic rf_relay_write = 0, rf_cmd_end = 0, carrier_on = 1, wait_extension_enable = 0;
    logic [6:0] own_addr = 7'h00, host_addr = 7'h00;
    logic [7:0] host_cmd_code = 8'h00, lat = 8'h14, host_rsp_status;
    logic exclusive, host_rsp_valid, host_exec, host_irq, relay_irq, relay_is_write, relay_done;
    logic relay_fail, relay_timeout, rf_exec, rf_wtx, rf_drop, host_exec_done, rf_rsp_done;
    logic cur_wr = 0, clk_en = 1;
    logic [7:0] codes [5] = '{CMD_READ, CMD_WRITE, CMD_STATUS, CMD_REG_WRITE, CMD_REG_READ};
    int fails = 0, num_checks = 0, irq_cnt = 0, done_cnt = 0, to_cnt = 0, k = 0, seed;
    always #2 clk = ~clk;
    dpa_arbiter #(.ANSWER_WAIT_CYCLES(AW)) u_dpa_arbiter (.clk(clk), .rst_n(rst_n),
        .clk_en(clk_en), .own_addr(own_addr), .host_cmd_start(host_cmd_start),
        .host_cmd_valid(host_cmd_valid), .host_addr(host_addr), .host_cmd_code(host_cmd_code),
        .host_rf_stop(host_rf_stop), .host_selfdiag_err(host_selfdiag_err),
        .host_exec_done(host_exec_done), .rf_cmd_start(rf_cmd_start), .rf_iso(rf_iso),
        .rf_wtx_kind(rf_wtx_kind), .rf_relay(rf_relay), .rf_relay_write(rf_relay_write),
        .rf_cmd_end(rf_cmd_end), .rf_rsp_done(rf_rsp_done), .carrier_on(carrier_on),
        .wait_extension_enable(wait_extension_enable), .exclusive(exclusive),
        .host_rsp_valid(host_rsp_valid), .host_rsp_status(host_rsp_status),
        .host_exec(host_exec), .host_irq(host_irq), .relay_irq(relay_irq),
        .relay_is_write(relay_is_write), .relay_done(relay_done), .relay_fail(relay_fail),
        .relay_timeout(relay_timeout), .rf_exec(rf_exec), .rf_wtx(rf_wtx), .rf_drop(rf_drop));
    dpa_far_end u_dpa_far_end (.clk(clk), .rst_n(rst_n), .host_exec(host_exec),
        .rf_exec(rf_exec), .lat(lat), .host_exec_done(host_exec_done),
        .rf_rsp_done(rf_rsp_done));
    // Pulse counters, so single-cycle events are never missed between samples
    always @(posedge clk) begin
        irq_cnt <= irq_cnt + int'(host_irq === 1'b1);
        done_cnt <= done_cnt + int'(relay_done === 1'b1);
        to_cnt <= to_cnt + int'(relay_timeout === 1'b1);
    end
    // ----------------------------------------
    // Compare tasks and reference model
    // ----------------------------------------
    task chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    // States: 0 idle, 1 RF busy, 2 serial busy, 3 await query, 4 await answer
    // Returns FF for execution; r[0] marks RF stop, r[1] a self-diagnosis failure
    function automatic logic [7:0] ref_rsp(input int st, input logic [7:0] c, input logic [1:0] r);
        logic [7:0] det;
        logic reg_op;
        det = cur_wr ? ST_RELAY_WR : ST_RELAY_RD;
        reg_op = (c == CMD_REG_WRITE) || (c == CMD_REG_READ);
        if (st == 2) return ST_HOST_BUSY;
        if (c == CMD_QUERY) return (st == 3) ? ST_NORMAL : (st == 4) ? ST_UNIMPL : ST_RELAY_ERR;
        if (c == CMD_ANSWER_OK || c == CMD_ANSWER_ERR)
            return (st == 4) ? ST_NORMAL : (st == 3) ? ST_UNIMPL : ST_RELAY_ERR;
        if (!reg_op && c != CMD_READ && c != CMD_WRITE && c != CMD_STATUS) return ST_UNIMPL;
        if (st == 0) return 8'hFF;
        if (!reg_op) return (st == 1) ? ST_BUSY : (c == CMD_STATUS) ? det : ST_UNIMPL;
        if (r[1]) return ST_SELFDIAG;
        return (st == 3 && !(c == CMD_REG_WRITE && r[0])) ? det : ST_NORMAL;
    endfunction
    // ----------------------------------------
    // Drivers; each leaves a gap cycle so no strobe is set twice in one step
    // ----------------------------------------
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task host(input int st, input logic [7:0] c, input logic [1:0] r, input logic bad);
        logic [7:0] e;
        e = bad ? 8'hFE : ref_rsp(st, c, r);
        host_addr = bad ? own_addr ^ 7'h01 : own_addr;
        host_cmd_start = 1;
        host_cmd_valid = 1;
        host_cmd_code = c;
        {host_selfdiag_err, host_rf_stop} = r;
        tick(1);
        host_cmd_start = 0;
        host_cmd_valid = 0;
        chk_bit(host_exec, e == 8'hFF);
        if (e != 8'hFF) chk_bit(host_rsp_valid, e != 8'hFE);
        if (e < 8'hFE) chk_byte(host_rsp_status, e);
        tick(1);
    endtask
    // e is {exec, wtx, drop}; 111 skips the check
    task rf(input logic [3:0] kind, input logic [2:0] e);
        rf_cmd_start = 1;
        {rf_iso, rf_wtx_kind, rf_relay, rf_relay_write} = kind;
        tick(1);
        rf_cmd_start = 0;
        if (e != 3'b111) chk_byte({5'h00, rf_exec, rf_wtx, rf_drop}, {5'h00, e});
        tick(1);
    endtask
    function automatic logic sel(input int w);
        case (w)
            0: return host_irq;
            1: return relay_irq;
            2: return relay_timeout;
            default: return !exclusive;
        endcase
    endfunction
    task wait_for(input int w, input int lim);
        int n;
        n = 0;
        while (n < lim && sel(w) !== 1'b1) begin
            tick(1);
            n++;
        end
        chk_bit(sel(w), 1'b1);
    endtask
    // Opens a relay; with hit a host STATUS lands right after reception ends
    task relay_open(input logic wr, input logic hit);
        cur_wr = wr;
        rf({2'b00, 1'b1, wr}, 3'b111);
        chk_bit(exclusive, 1'b1);
        rf_cmd_end = 1;
        tick(1);
        rf_cmd_end = 0;
        if (hit) host(1, CMD_STATUS, 2'b00, 0);
        if (hit) chk_bit(relay_irq, 1'b1);
        wait_for(1, 4);
        chk_bit(relay_is_write, wr);
    endtask
    task give_verdict;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog sized well beyond the few hundred cycles the sequence needs
    initial begin
        #(4 * 4000);
        fails++;
        give_verdict;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hE1AC;
        own_addr = 7'($random(seed));
        lat = 8'h14 + 8'($random(seed) & 7);
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1;
        chk_byte({exclusive, host_rsp_valid, host_exec, host_irq, relay_irq, rf_exec, rf_drop,
            relay_timeout}, 8'h00);
        host(0, 8'h77, 2'b00, 0);
        host(0, CMD_READ, 2'b00, 1);
        host(0, CMD_READ, 2'b00, 0);
        chk_bit(exclusive, 1'b1);
        host(2, CMD_STATUS, 2'b00, 0);
        host(2, CMD_QUERY, 2'b00, 0);
        rf(4'b0000, 3'b001);
        rf(4'b1100, 3'b001);
        wait_extension_enable = 1;
        rf(4'b1100, 3'b010);
        rf(4'b1000, 3'b100);
        wait_extension_enable = 0;
        k = irq_cnt;
        wait_for(0, 40);
        tick(2);
        chk_byte(8'(irq_cnt - k), 8'h01);
        chk_bit(exclusive, 1'b0);
        tick(40);
        rf(4'b0000, 3'b100);
        for (int i = 0; i < 5; i++) host(1, codes[i], 2'($random(seed)), 0);
        host(1, CMD_QUERY, 2'b00, 0);
        host(1, CMD_ANSWER_OK, 2'b00, 0);
        rf(4'b0000, 3'b001);
        wait_for(3, 40);
        relay_open(1, 1);
        for (int i = 0; i < 5; i++) host(3, codes[i], 2'($random(seed)), 0);
        host(3, CMD_REG_WRITE, 2'b01, 0);
        host(3, CMD_ANSWER_OK, 2'b00, 0);
        wait_extension_enable = 1;
        rf(4'b1100, 3'b001);
        wait_extension_enable = 0;
        rf(4'b0000, 3'b001);
        host(3, CMD_QUERY, 2'b00, 0);
        for (int i = 0; i < 5; i++) host(4, codes[i], 2'($random(seed)), 0);
        host(4, CMD_QUERY, 2'b00, 0);
        k = to_cnt;
        repeat (4) begin
            tick(14);
            host(4, CMD_STATUS, 2'b00, 0);
        end
        chk_byte(8'(to_cnt - k), 8'h00);
        k = done_cnt;
        host(4, CMD_ANSWER_ERR, 2'b00, 0);
        chk_byte(8'(done_cnt - k), 8'h01);
        chk_bit(relay_fail, 1'b1);
        chk_bit(exclusive, 1'b0);
        relay_open(0, 0);
        host(3, CMD_STATUS, 2'b00, 0);
        host(3, CMD_QUERY, 2'b00, 0);
        k = to_cnt;
        tick(12);
        chk_byte(8'(to_cnt - k), 8'h00);
        // A frozen clock enable must stop the answer-wait timer as well
        clk_en = 0;
        tick(10);
        clk_en = 1;
        chk_bit(exclusive, 1'b1);
        chk_byte(8'(to_cnt - k), 8'h00);
        wait_for(2, 20);
        tick(1);
        chk_bit(exclusive, 1'b0);
        relay_open(0, 0);
        host(3, CMD_QUERY, 2'b00, 0);
        host(4, CMD_ANSWER_OK, 2'b00, 0);
        chk_bit(relay_fail, 1'b0);
        chk_bit(exclusive, 1'b0);
        relay_open(0, 0);
        carrier_on = 0;
        tick(1);
        carrier_on = 1;
        wait_for(3, 2);
        give_verdict;
    end
endmodule // tb_top
